// file: rtl/fesc_cfg.svh
// Constants for the flash erase and security controller.
// Assumes 8-bit internal SFR and 16-bit external SFR addressing.
`ifndef FESC_CFG_SVH
`define FESC_CFG_SVH

`define FESC_ADDR_ERASE_TRIG   8'h94
`define FESC_ADDR_FLASH_CTL    8'hb2
`define FESC_ADDR_PAGE_SEL     8'hb7
`define FESC_ADDR_BURN_PULSE   16'hffd1
`define FESC_ADDR_FUSE_SETUP   16'hffd2
`define FESC_ADDR_SEC_STATUS   16'hffd7

`define FESC_PAT_PAGE_ERASE    8'h55
`define FESC_PAT_MASS_ERASE    8'haa
`define FESC_PAT_FUSE_SETUP    8'h54
`define FESC_PAT_FUSE_MODE0    8'h81
`define FESC_PAT_FUSE_MODE1    8'h82
`define FESC_PAT_BURN          8'ha6

`define FESC_BIT_PWE           0
`define FESC_BIT_MEEN          1
`define FESC_BIT_SECURE        6
`define FESC_BIT_FUSE_MODE1    0
`define FESC_BIT_FUSE_MODE0    1
`define FESC_BIT_SEC_PIN       5

`define FESC_RST_BYTE          8'h00
`define FESC_PAGE_COUNT        128
`define FESC_PAGE_BYTES        512
`define FESC_PAGE_MSB          15
`define FESC_PAGE_LSB          9
`define FESC_PAGE_ZERO         7'h00

`endif

// file: rtl/fesc_pkg.sv
// Types shared by the flash erase and security controller.
// Constants live in fesc_cfg.svh.
package fesc_pkg;

	typedef enum logic [2:0] {
		FESC_IDLE       = 3'b001,
		FESC_PAGE_ERASE = 3'b010,
		FESC_MASS_ERASE = 3'b100
	} fesc_state_e;

	typedef enum logic [2:0] {
		FESC_FUSE_OFF   = 3'b001,
		FESC_FUSE_SETUP = 3'b010,
		FESC_FUSE_SEL   = 3'b100
	} fesc_fuse_e;

endpackage

// file: rtl/fesc_sync2.sv
// Two-stage synchroniser for levels from pins and fuse sense lines.
// Assumes the input is quasi-static relative to clk.
`timescale 1ns/1ps
`default_nettype none

module fesc_sync2 (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);

	logic meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: rtl/fesc_arm_flag.sv
// Sticky arming flag: set by software, consumed by hardware.
// Same-cycle set and clear keeps the flag set.
`timescale 1ns/1ps
`default_nettype none

module fesc_arm_flag (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	always_ff @(posedge clk) begin
		if (rst)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end

endmodule

`default_nettype wire

// file: rtl/fesc_ctrl.sv
// Flash erase, flash byte write and program security controller.
// Sits between the core's SFR and external-data write paths and the
// flash array, fuses, emulator port and security pin; one clock.
//
// Summary of operation
// - 0x55 to erase trigger starts page erase
// - 0xAA mass erase needs enable and debug port
// - Other trigger values start nothing but clear both arming flags
// - 128 pages of 512 bytes each
// - Mass erase enable rewritten per mass erase
// - Write enable steers stores to flash
// - Write enable clears after each flash byte
// - Write enable writes ignored with interrupts on
// - Security bit set-only, cleared by reset
// - Secure emulator may only bulk erase
// - Secure protects page zero from erase, write
// - Global erase also clears data RAM
// - Mode 0 ends by erase then reset
// - Security bit needs mode 0 fuse blown
// - Secure blocks external code and data reads
// - Mode 1 fuse disables emulator, latched once seen
// - Mode 1 burn only while pin high
// - Security pin level readable in bit 5
// - 0xA6 burns, other values stop burning
`timescale 1ns/1ps
`default_nettype none

`include "fesc_cfg.svh"

module fesc_ctrl #(
	parameter int PAGE_COUNT = `FESC_PAGE_COUNT,
	parameter int PAGE_BYTES = `FESC_PAGE_BYTES
) (
	input  wire logic        clk,
	input  wire logic        rst,
	// Internal SFR port
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	// External SFR port
	input  wire logic        xsfr_wr,
	input  wire logic        xsfr_rd,
	input  wire logic [15:0] xsfr_addr,
	input  wire logic [7:0]  xsfr_wdata,
	output logic      [7:0]  xsfr_rdata,
	// Core store through the data pointer
	input  wire logic        store_wr,
	input  wire logic [15:0] store_addr,
	input  wire logic [7:0]  store_data,
	input  wire logic        irq_enabled,
	output logic             xram_wr,
	output logic      [15:0] xram_addr,
	output logic      [7:0]  xram_wdata,
	output logic             xram_clear,
	// Flash array
	output logic             flash_wr,
	output logic      [15:0] flash_addr,
	output logic      [7:0]  flash_wdata,
	output logic             flash_page_erase,
	output logic             flash_mass_erase,
	output logic      [6:0]  flash_erase_page,
	input  wire logic        flash_done,
	output logic             erase_busy,
	// Fuses, security pin, emulator port
	input  wire logic        mode0_security_fuse,
	input  wire logic        mode1_security_fuse,
	input  wire logic        security_pin,
	output logic             fuse_burn_mode0,
	output logic             fuse_burn_mode1,
	input  wire logic        ice_attached,
	input  wire logic        ice_bulk_erase,
	output logic             ice_enabled,
	output logic             ice_full_access,
	output logic             ext_read_block
);

	fesc_pkg::fesc_state_e state_q;
	fesc_pkg::fesc_fuse_e  fuse_q;

	logic       fuse0_s;
	logic       fuse1_s;
	logic       sec_pin_s;
	logic       ice_att_s;
	logic       ice_erase_s;
	logic       ice_erase_d1_q;
	logic       ice_off_q;
	logic       secure_q;
	logic       pwe_q;
	logic [7:0] page_sel_q;
	logic       page_armed;
	logic       meen_armed;
	logic       fuse_mode1_q;
	logic       burn_q;

	logic wr_trig;
	logic wr_ctl;
	logic wr_page;
	logic wr_setup;
	logic wr_pulse;
	logic idle;
	logic page_zero;
	logic start_page;
	logic start_mass;
	logic ice_mass;
	logic store_flash;

	fesc_sync2 u_sync_fuse0 (
		.clk (clk),
		.rst (rst),
		.d   (mode0_security_fuse),
		.q   (fuse0_s)
	);

	fesc_sync2 u_sync_fuse1 (
		.clk (clk),
		.rst (rst),
		.d   (mode1_security_fuse),
		.q   (fuse1_s)
	);

	fesc_sync2 u_sync_pin (
		.clk (clk),
		.rst (rst),
		.d   (security_pin),
		.q   (sec_pin_s)
	);

	fesc_sync2 u_sync_ice (
		.clk (clk),
		.rst (rst),
		.d   (ice_attached),
		.q   (ice_att_s)
	);

	fesc_sync2 u_sync_ice_erase (
		.clk (clk),
		.rst (rst),
		.d   (ice_bulk_erase),
		.q   (ice_erase_s)
	);

	// Decodes
	assign wr_trig  = sfr_wr && (sfr_addr == `FESC_ADDR_ERASE_TRIG);
	assign wr_ctl   = sfr_wr && (sfr_addr == `FESC_ADDR_FLASH_CTL);
	assign wr_page  = sfr_wr && (sfr_addr == `FESC_ADDR_PAGE_SEL);
	assign wr_setup = xsfr_wr && (xsfr_addr == `FESC_ADDR_FUSE_SETUP);
	assign wr_pulse = xsfr_wr && (xsfr_addr == `FESC_ADDR_BURN_PULSE);

	assign idle = (state_q == fesc_pkg::FESC_IDLE);

	// Page select bits 7:1 name one of 128 pages, bit 0 unused
	assign page_zero = (page_sel_q[7:1] == `FESC_PAGE_ZERO);

	// Erase triggers; any other pattern starts nothing, though the write still disarms
	assign start_page = idle && wr_trig && page_armed &&
		(sfr_wdata == `FESC_PAT_PAGE_ERASE) &&
		!(secure_q && page_zero);
	assign start_mass = idle && wr_trig && meen_armed &&
		(sfr_wdata == `FESC_PAT_MASS_ERASE) &&
		ice_enabled && ice_att_s;

	// Emulator bulk erase: rising edge of its synchronised request
	assign ice_mass = idle && ice_enabled && ice_att_s &&
		ice_erase_s && !ice_erase_d1_q;

	always_ff @(posedge clk) begin
		if (rst)
			ice_erase_d1_q <= 1'b0;
		else
			ice_erase_d1_q <= ice_erase_s;
	end

	// Arming flags consumed by any erase trigger write while idle
	fesc_arm_flag u_page_arm (
		.clk (clk),
		.rst (rst),
		.set (wr_page && idle),
		.clr (wr_trig && idle),
		.q   (page_armed)
	);

	fesc_arm_flag u_meen_arm (
		.clk (clk),
		.rst (rst),
		.set (wr_ctl && idle && sfr_wdata[`FESC_BIT_MEEN]),
		.clr (wr_trig && idle),
		.q   (meen_armed)
	);

	always_ff @(posedge clk) begin
		if (rst)
			page_sel_q <= `FESC_RST_BYTE;
		else if (wr_page && idle)
			page_sel_q <= sfr_wdata;
	end

	// Erase sequencer; the array reports the end with flash_done
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= fesc_pkg::FESC_IDLE;
		end else begin
			case (state_q)
				fesc_pkg::FESC_IDLE: begin
					if (start_mass || ice_mass)
						state_q <= fesc_pkg::FESC_MASS_ERASE;
					else if (start_page)
						state_q <= fesc_pkg::FESC_PAGE_ERASE;
				end
				fesc_pkg::FESC_PAGE_ERASE,
				fesc_pkg::FESC_MASS_ERASE: begin
					if (flash_done)
						state_q <= fesc_pkg::FESC_IDLE;
				end
				default: state_q <= fesc_pkg::FESC_IDLE;
			endcase
		end
	end

	// Erase commands are one-cycle pulses with the page held
	always_ff @(posedge clk) begin
		if (rst) begin
			flash_page_erase <= 1'b0;
			flash_mass_erase <= 1'b0;
			xram_clear       <= 1'b0;
			flash_erase_page <= 7'h00;
		end else begin
			flash_page_erase <= start_page && !(start_mass || ice_mass);
			flash_mass_erase <= start_mass || ice_mass;
			xram_clear       <= start_mass || ice_mass;
			if (start_page)
				flash_erase_page <= page_sel_q[7:1];
		end
	end

	assign erase_busy = !idle;

	// Write enable: interrupts must be off for a write to take
	always_ff @(posedge clk) begin
		if (rst)
			pwe_q <= 1'b0;
		else if (store_flash)
			pwe_q <= 1'b0;
		else if (wr_ctl && !irq_enabled)
			pwe_q <= sfr_wdata[`FESC_BIT_PWE];
	end

	// Set-only; needs the mode 0 fuse; only reset clears it
	always_ff @(posedge clk) begin
		if (rst)
			secure_q <= 1'b0;
		else if (wr_ctl && sfr_wdata[`FESC_BIT_SECURE] && fuse0_s)
			secure_q <= 1'b1;
	end

	// Mode 1 fuse latches the port off once seen; the fuse sync clears
	// in reset, so the port stays open three cycles after release only
	always_ff @(posedge clk) begin
		if (rst)
			ice_off_q <= 1'b0;
		else if (fuse1_s)
			ice_off_q <= 1'b1;
	end

	assign ice_enabled     = !ice_off_q;
	assign ice_full_access = ice_enabled && !secure_q;
	assign ext_read_block  = secure_q || ice_off_q;

	// Store routing: flash while enabled, else data RAM
	assign store_flash = store_wr && pwe_q && idle &&
		!(secure_q &&
		store_addr[`FESC_PAGE_MSB:`FESC_PAGE_LSB] == `FESC_PAGE_ZERO);

	always_ff @(posedge clk) begin
		if (rst) begin
			flash_wr    <= 1'b0;
			xram_wr     <= 1'b0;
			flash_addr  <= 16'h0000;
			flash_wdata <= 8'h00;
			xram_addr   <= 16'h0000;
			xram_wdata  <= 8'h00;
		end else begin
			flash_wr <= store_flash;
			xram_wr  <= store_wr && !pwe_q;
			if (store_flash) begin
				flash_addr  <= store_addr;
				flash_wdata <= store_data;
			end
			if (store_wr && !pwe_q) begin
				xram_addr  <= store_addr;
				xram_wdata <= store_data;
			end
		end
	end

	// Fuse burn sequence: setup, then mode select, then pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			fuse_q       <= fesc_pkg::FESC_FUSE_OFF;
			fuse_mode1_q <= 1'b0;
		end else if (wr_setup) begin
			case (fuse_q)
				fesc_pkg::FESC_FUSE_OFF: begin
					if (xsfr_wdata == `FESC_PAT_FUSE_SETUP)
						fuse_q <= fesc_pkg::FESC_FUSE_SETUP;
				end
				fesc_pkg::FESC_FUSE_SETUP,
				fesc_pkg::FESC_FUSE_SEL: begin
					if (xsfr_wdata == `FESC_PAT_FUSE_MODE0) begin
						fuse_q       <= fesc_pkg::FESC_FUSE_SEL;
						fuse_mode1_q <= 1'b0;
					end else if (xsfr_wdata == `FESC_PAT_FUSE_MODE1) begin
						fuse_q       <= fesc_pkg::FESC_FUSE_SEL;
						fuse_mode1_q <= 1'b1;
					end else if (xsfr_wdata == `FESC_PAT_FUSE_SETUP) begin
						fuse_q <= fesc_pkg::FESC_FUSE_SETUP;
					end else begin
						fuse_q <= fesc_pkg::FESC_FUSE_OFF;
					end
				end
				default: fuse_q <= fesc_pkg::FESC_FUSE_OFF;
			endcase
		end
	end

	// Burning lasts until software writes any other value
	always_ff @(posedge clk) begin
		if (rst)
			burn_q <= 1'b0;
		else if (wr_pulse)
			burn_q <= (xsfr_wdata == `FESC_PAT_BURN) &&
				(fuse_q == fesc_pkg::FESC_FUSE_SEL);
	end

	// Mode 1 burn drops two cycles after the pin falls mid-pulse
	assign fuse_burn_mode0 = burn_q && !fuse_mode1_q;
	assign fuse_burn_mode1 = burn_q && fuse_mode1_q && sec_pin_s;

	// Registered read data; write-only bits and unmapped read 0
	always_ff @(posedge clk) begin
		if (rst) begin
			sfr_rdata <= `FESC_RST_BYTE;
		end else if (sfr_rd) begin
			sfr_rdata <= `FESC_RST_BYTE;
			if (sfr_addr == `FESC_ADDR_FLASH_CTL) begin
				sfr_rdata[`FESC_BIT_PWE]    <= pwe_q;
				sfr_rdata[`FESC_BIT_SECURE] <= secure_q;
			end else if (sfr_addr == `FESC_ADDR_PAGE_SEL) begin
				sfr_rdata <= page_sel_q;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			xsfr_rdata <= `FESC_RST_BYTE;
		end else if (xsfr_rd) begin
			xsfr_rdata <= `FESC_RST_BYTE;
			if (xsfr_addr == `FESC_ADDR_SEC_STATUS) begin
				xsfr_rdata[`FESC_BIT_SEC_PIN]    <= sec_pin_s;
				xsfr_rdata[`FESC_BIT_FUSE_MODE0] <= fuse0_s;
				xsfr_rdata[`FESC_BIT_FUSE_MODE1] <= fuse1_s;
			end
		end
	end

endmodule

`default_nettype wire

// file: verif/fesc_ctrl_asserts.sv
// Port assertions for the flash erase and security controller.
// Bound into fesc_ctrl; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fesc_ctrl_asserts (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_addr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        store_wr,
	input wire logic [15:0] store_addr,
	input wire logic        xram_wr,
	input wire logic [15:0] xram_addr,
	input wire logic        xram_clear,
	input wire logic        flash_wr,
	input wire logic [15:0] flash_addr,
	input wire logic        flash_page_erase,
	input wire logic        flash_mass_erase,
	input wire logic        flash_done,
	input wire logic        erase_busy,
	input wire logic        security_pin,
	input wire logic        fuse_burn_mode0,
	input wire logic        fuse_burn_mode1,
	input wire logic        ice_bulk_erase,
	input wire logic        ice_enabled,
	input wire logic        ice_full_access
);
	logic trig;
	assign trig = sfr_wr && sfr_addr == 8'h94;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_page_erase_cause: assert property (
		flash_page_erase |-> $past(trig && sfr_wdata == 8'h55))
		else $error("page erase without trigger");
	a_mass_erase_cause: assert property (
		flash_mass_erase |-> $past(trig && sfr_wdata == 8'haa)
		|| $past(ice_bulk_erase, 2))
		else $error("mass erase without request");
	a_mass_clears_ram: assert property (
		flash_mass_erase |-> xram_clear)
		else $error("mass erase left data RAM");
	a_flash_store: assert property (
		flash_wr |-> $past(store_wr) && flash_addr == $past(store_addr))
		else $error("flash write not from store");
	a_ram_store: assert property (
		xram_wr |-> $past(store_wr) && xram_addr == $past(store_addr))
		else $error("ram write not from store");
	a_one_flash_byte: assert property (
		flash_wr |=> !flash_wr)
		else $error("write enable not cleared");
	a_erase_sets_busy: assert property (
		(flash_page_erase || flash_mass_erase) |->
		erase_busy && !$past(erase_busy))
		else $error("erase started while busy");
	a_done_ends_busy: assert property (
		erase_busy && flash_done |=> !erase_busy)
		else $error("busy outlived done");
	a_burn1_needs_pin: assert property (
		fuse_burn_mode1 |-> $past(security_pin, 2))
		else $error("mode 1 burn with pin low");
	a_one_fuse_burn: assert property (
		!(fuse_burn_mode0 && fuse_burn_mode1))
		else $error("two fuses burning");
	a_full_needs_ice: assert property (
		ice_full_access |-> ice_enabled)
		else $error("full access with port off");
endmodule
`default_nettype wire

// file: verif/fesc_flash_model.sv
// Flash array and fuse model facing the controller.
// Assumes one-cycle erase pulses; fuses never heal, even over reset.
`timescale 1ns/1ps
`default_nettype none
module fesc_flash_model #(
	parameter int ERASE_CYC = 12,
	parameter int BURN_CYC  = 8
) (
	input  wire logic clk,
	input  wire logic page_erase,
	input  wire logic mass_erase,
	input  wire logic burn0,
	input  wire logic burn1,
	output logic      done,
	output logic      fuse0,
	output logic      fuse1
);
	int ecnt = 0;
	int b0   = 0;
	int b1   = 0;
	initial begin
		done = 1'h0;
		fuse0 = 1'h0;
		fuse1 = 1'h0;
	end
	always @(posedge clk) begin
		done <= ecnt == 1;
		if (page_erase || mass_erase)
			ecnt <= ERASE_CYC;
		else if (ecnt > 0)
			ecnt <= ecnt - 1;
	end
	// Short burns must not blow a fuse
	always @(posedge clk) begin
		b0 <= burn0 ? b0 + 1 : 0;
		b1 <= burn1 ? b1 + 1 : 0;
		if (b0 == BURN_CYC)
			fuse0 <= 1'h1;
		if (b1 == BURN_CYC)
			fuse1 <= 1'h1;
	end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the flash erase and security controller.
// Assumes fesc_flash_model answers erases and blows fuses on long burns.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [7:0] pg;
		logic [7:0] pat;
		logic       meen;
		logic       ice;
		logic       pe;
		logic       me;
		logic [6:0] page;
	} fesc_row_s;
	logic        clk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0;
	logic        xsfr_wr = 1'h0, xsfr_rd = 1'h0, store_wr = 1'h0;
	logic        irq_enabled = 1'h0, security_pin = 1'h0;
	logic        ice_attached = 1'h0, ice_bulk_erase = 1'h0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, xsfr_wdata = 8'h00;
	logic [7:0]  store_data = 8'h00, sfr_rdata, xsfr_rdata, rd;
	logic [15:0] xsfr_addr = 16'h0000, store_addr = 16'h0000;
	logic        xram_wr, xram_clear, flash_wr, flash_page_erase;
	logic        flash_mass_erase, erase_busy, flash_done, ext_read_block;
	logic        mode0_security_fuse, mode1_security_fuse;
	logic        fuse_burn_mode0, fuse_burn_mode1, ice_enabled;
	logic        ice_full_access;
	logic [15:0] xram_addr, flash_addr;
	logic [7:0]  xram_wdata, flash_wdata;
	logic [6:0]  flash_erase_page, last_pg = 7'h00;
	int          failures = 0, tests_run = 0;
	int          n_pe = 0, n_me = 0, n_fw = 0, n_xw = 0, n_xc = 0;
	int          pe0, me0, fw0, xw0, xc0;
	localparam logic [7:0] RA [4] = '{8'hb2, 8'hb7, 8'h94, 8'h80};
	fesc_row_s rows [9] = '{
		'{8'h06, 8'h55, 1'h0, 1'h1, 1'h1, 1'h0, 7'h03},
		'{8'hff, 8'h55, 1'h0, 1'h1, 1'h1, 1'h0, 7'h7f},
		'{8'h03, 8'h55, 1'h0, 1'h1, 1'h1, 1'h0, 7'h01},
		'{8'h01, 8'h55, 1'h0, 1'h1, 1'h1, 1'h0, 7'h00},
		'{8'h00, 8'haa, 1'h1, 1'h1, 1'h0, 1'h1, 7'h00},
		'{8'h00, 8'haa, 1'h0, 1'h1, 1'h0, 1'h0, 7'h00},
		'{8'h00, 8'haa, 1'h1, 1'h0, 1'h0, 1'h0, 7'h00},
		'{8'h08, 8'h12, 1'h1, 1'h1, 1'h0, 1'h0, 7'h00},
		'{8'h08, 8'h00, 1'h1, 1'h1, 1'h0, 1'h0, 7'h00}};
	fesc_ctrl i_dut (.*);
	fesc_flash_model i_flash (
		.clk       (clk),
		.page_erase(flash_page_erase),
		.mass_erase(flash_mass_erase),
		.burn0     (fuse_burn_mode0),
		.burn1     (fuse_burn_mode1),
		.done      (flash_done),
		.fuse0     (mode0_security_fuse),
		.fuse1     (mode1_security_fuse)
	);
	always #4 clk = ~clk;
	always @(posedge clk) begin
		n_pe <= n_pe + flash_page_erase;
		n_me <= n_me + flash_mass_erase;
		n_fw <= n_fw + flash_wr;
		n_xw <= n_xw + xram_wr;
		n_xc <= n_xc + xram_clear;
		if (flash_page_erase)
			last_pg <= flash_erase_page;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		tests_run++;
		if (seen !== e) begin
			failures++;
			$display("BAD %s expected %0h seen %0h", nm, e, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task sw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'h1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'h0;
	endtask
	task sr(input logic [7:0] a);
		@(posedge clk);
		sfr_rd <= 1'h1;
		sfr_addr <= a;
		cyc(1);
		sfr_rd <= 1'h0;
		cyc(1);
		#1 rd = sfr_rdata;
	endtask
	task xw(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		xsfr_wr <= 1'h1;
		xsfr_addr <= a;
		xsfr_wdata <= d;
		@(posedge clk);
		xsfr_wr <= 1'h0;
	endtask
	task xr(input logic [15:0] a);
		@(posedge clk);
		xsfr_rd <= 1'h1;
		xsfr_addr <= a;
		cyc(1);
		xsfr_rd <= 1'h0;
		cyc(1);
		#1 rd = xsfr_rdata;
	endtask
	task st(input logic [15:0] a);
		@(posedge clk);
		store_wr <= 1'h1;
		store_addr <= a;
		store_data <= a[7:0] ^ 8'h5a;
		@(posedge clk);
		store_wr <= 1'h0;
	endtask
	// Core clock taken as already set for flash work
	task burn(input logic [7:0] m);
		xw(16'hffd2, 8'h54);
		xw(16'hffd2, m);
		xw(16'hffd1, 8'ha6);
		cyc(2);
	endtask
	task drain;
		cyc(3);
		for (int i = 0; i < 100 && erase_busy !== 1'h0; i++)
			cyc(1);
		#1 pe0 = pe0;
	endtask
	task snap;
		pe0 = n_pe;
		me0 = n_me;
		fw0 = n_fw;
		xw0 = n_xw;
		xc0 = n_xc;
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400000 failures++;
		end_sim;
	end
	initial begin
		cyc(2);
		rst <= 1'h0;
		foreach (RA[i]) begin
			sr(RA[i]);
			chk("reset_read", rd, 8'h00);
		end
		xr(16'hffd7);
		chk("status_reset", rd, 8'h00);
		foreach (rows[i]) begin
			ice_attached <= rows[i].ice;
			sw(8'hb7, rows[i].pg);
			sw(8'hb2, {6'h0, rows[i].meen, 1'h0});
			snap;
			sw(8'h94, rows[i].pat);
			drain;
			chk("page_erase", n_pe - pe0, rows[i].pe);
			chk("mass_erase", n_me - me0, rows[i].me);
			chk("ram_clear", n_xc - xc0, rows[i].me);
			chk("erase_page", last_pg, rows[i].page);
		end
		snap;
		sw(8'hb7, 8'h0a);
		sw(8'h94, 8'h55);
		sw(8'hb7, 8'h0c);
		sw(8'h94, 8'h55);
		drain;
		sw(8'h94, 8'h55);
		sw(8'hb2, 8'h02);
		sw(8'h94, 8'haa);
		drain;
		sw(8'h94, 8'haa);
		drain;
		chk("rearm_page", n_pe - pe0, 1);
		chk("busy_page", last_pg, 7'h05);
		chk("rearm_mass", n_me - me0, 1);
		sw(8'hb2, 8'h01);
		st(16'h1234);
		sr(8'hb2);
		chk("pwe_clear", rd[0], 1'h0);
		chk("flash_addr", flash_addr, 16'h1234);
		chk("flash_data", flash_wdata, 8'h6e);
		st(16'h1235);
		irq_enabled <= 1'h1;
		sw(8'hb2, 8'h01);
		st(16'h1236);
		irq_enabled <= 1'h0;
		cyc(2);
		chk("flash_wr", n_fw - fw0, 1);
		chk("xram_wr", n_xw - xw0, 2);
		chk("xram_addr", xram_addr, 16'h1236);
		chk("xram_data", xram_wdata, 8'h6c);
		sw(8'hb2, 8'h40);
		sr(8'hb2);
		chk("secure_nofuse", rd[6], 1'h0);
		burn(8'h81);
		chk("burn0_on", fuse_burn_mode0, 1'h1);
		cyc(10);
		xw(16'hffd1, 8'h00);
		cyc(3);
		chk("burn0_off", fuse_burn_mode0, 1'h0);
		xr(16'hffd7);
		chk("fuse0", rd[1], 1'h1);
		sw(8'hb2, 8'h40);
		sw(8'hb2, 8'h00);
		sr(8'hb2);
		chk("secure_set", rd[6], 1'h1);
		chk("read_block", ext_read_block, 1'h1);
		chk("ice_limited", ice_full_access, 1'h0);
		snap;
		sw(8'hb7, 8'h00);
		sw(8'h94, 8'h55);
		drain;
		sw(8'hb2, 8'h41);
		st(16'h0010);
		ice_bulk_erase <= 1'h1;
		cyc(8);
		ice_bulk_erase <= 1'h0;
		drain;
		chk("page0_erase", n_pe - pe0, 0);
		chk("page0_write", n_fw - fw0, 0);
		chk("ice_bulk", n_me - me0, 1);
		chk("bulk_ram", n_xc - xc0, 1);
		sr(8'hb2);
		chk("still_secure", rd[6], 1'h1);
		rst <= 1'h1;
		cyc(4);
		rst <= 1'h0;
		sr(8'hb2);
		chk("secure_reset", rd[6], 1'h0);
		chk("ice_full", ice_full_access, 1'h1);
		burn(8'h82);
		chk("burn1_pinlow", fuse_burn_mode1, 1'h0);
		xw(16'hffd1, 8'h00);
		security_pin <= 1'h1;
		cyc(4);
		xr(16'hffd7);
		chk("pin_level", rd[5], 1'h1);
		burn(8'h82);
		chk("burn1_on", fuse_burn_mode1, 1'h1);
		cyc(10);
		xw(16'hffd1, 8'h00);
		cyc(3);
		security_pin <= 1'h0;
		rst <= 1'h1;
		cyc(4);
		rst <= 1'h0;
		cyc(4);
		chk("ice_off", ice_enabled, 1'h0);
		chk("mode1_block", ext_read_block, 1'h1);
		end_sim;
	end
endmodule
bind fesc_ctrl fesc_ctrl_asserts i_chk (.*);
`default_nettype wire
